// ### hw/tap_pkg.sv
// Constants and types shared by the scan test controller
package tap_pkg;

    // Register widths
    localparam int IR_W = 8;
    localparam int BND_W = 40;
    localparam int CTRL_W = 11;

    // Instruction register layout and fixed values
    localparam int IR_PARITY_BIT = 7;
    localparam logic [7:0] IR_RESET = 8'hff;
    localparam logic [7:0] IR_STATUS = 8'h81;

    // Data register reset values
    localparam logic [39:0] BND_RESET = 40'h00_0000_0000;
    localparam logic [10:0] CTRL_RESET = 11'h002;

    // Opcodes decoded here; every other code acts as bypass
    localparam logic [7:0] OPC_EXTEST = 8'h00;
    localparam logic [7:0] OPC_SAMPLE = 8'h82;
    localparam logic [7:0] OPC_INTEST = 8'h03;
    localparam logic [7:0] OPC_HIGHZ = 8'h06;
    localparam logic [7:0] OPC_RUNT = 8'h09;

    // Worst case number of test-clock rises with mode select high
    localparam int TLR_MAX_RISES = 5;
    localparam logic [2:0] RISE_CNT_MAX = 3'h7;

    // Controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

    // Data register placed in the scan path
    typedef enum logic [1:0] {
        SEL_BOUNDARY,
        SEL_CONTROL,
        SEL_BYPASS
    } dr_sel_t;

endpackage

// ### hw/pin_sync.sv
// Two-flop synchroniser for the test access pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= RST;
            sync_o <= RST;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // pin_sync
`default_nettype wire

// ### hw/scan_reg.sv
// Shift stage with per-bit shadow latches
`timescale 1ns/1ns
`default_nettype none
module scan_reg #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic capture_i,
    input wire logic [W-1:0] cap_data_i,
    input wire logic shift_i,
    input wire logic sdi_i,
    input wire logic update_i,
    output logic [W-1:0] shift_q_o,
    output logic [W-1:0] shadow_o
);
    // Shift stage: capture, shift toward bit 0, else hold
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shift_q_o <= RST;
        end else if (ce_i) begin
            if (clear_i) begin
                shift_q_o <= RST;
            end else if (capture_i) begin
                shift_q_o <= cap_data_i;
            end else if (shift_i) begin
                shift_q_o <= {sdi_i, shift_q_o[W-1:1]};
            end
        end
    end

    // Shadow latches load from the shift stage on update
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shadow_o <= RST;
        end else if (ce_i) begin
            if (clear_i) begin
                shadow_o <= RST;
            end else if (update_i) begin
                shadow_o <= shift_q_o;
            end
        end
    end
endmodule // scan_reg
`default_nettype wire

// ### hw/boundary_scan_tap_controller.sv
// Test access port controller with instruction and data scan registers
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Sixteen controller states: six may hold, ten always move on.
// - State advances on each test-clock rise by the mode-select level.
// - Two scan paths, data or instruction, only one accessed at once.
// - Power-up lands in reset state with test logic reset and idle.
// - Mode select held high reaches reset state within five clocks.
// - Reset state loads instruction register with all ones, meaning bypass.
// - Reset state clears every boundary chain cell to zero.
// - Reset state loads control register with signature analysis, no mask.
// - Control register test operation runs only in run-test/idle.
// - Scan select states do nothing and last one test clock.
// - Data capture loads boundary chain or bypass on the rise leaving capture; control register keeps its shift stage.
// - Data shift drives serial out from first fall, data LSB.
// - Instruction shift drives serial out from first fall, instruction LSB.
// - One shift per rise; not on entry rise, yes on exit rise.
// - First fall in exit-1 state returns serial out to high impedance.
// - Exit-2 states may return to shift keeping contents, no recapture.
// - Pause states hold shift contents indefinitely.
// - Data shadow latches update on fall after entering data update.
// - Instruction capture loads fixed status pattern on exiting rise.
// - New instruction takes effect on fall after entering update.
// - Instruction register is eight bits with even parity in bit 7.
// - Unimplemented opcodes act as bypass.
// - Test registers have shift stage and shadow; bypass has none.
// - Inputs sampled on test-clock rise; serial out changes on fall.
// - Data registers: 40-bit chain, 11-bit control, 1-bit bypass.
// - Bypass register captures zero during data capture.
module boundary_scan_tap_controller (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [39:0] bnd_capture_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic test_mode_o,
    output logic outputs_highz_o,
    output logic run_test_o,
    output logic [39:0] bnd_drive_o,
    output logic [10:0] boundary_control_reg_o,
    output logic [7:0] instruction_o
);
    tap_pkg::tap_state_t state_q;
    tap_pkg::tap_state_t state_d;
    tap_pkg::dr_sel_t dr_sel;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_prev_q;
    logic rise_ev;
    logic fall_ev;
    logic in_tlr;
    logic bypass_q;
    logic [7:0] ir_shift;
    logic [7:0] ir_q;
    logic [39:0] bnd_shift;
    logic [10:0] ctrl_shift;
    logic bnd_cap;
    logic bnd_upd;
    logic ctrl_upd;
    logic serial_bit;

    // Even parity over all eight bits including bit 7
    function automatic logic parity_ok(input logic [7:0] code);
        parity_ok = ~(^code);
    endfunction

    // Data register chosen by an instruction
    function automatic tap_pkg::dr_sel_t dr_of(input logic [7:0] code);
        if (!parity_ok(code)) begin
            dr_of = tap_pkg::SEL_BYPASS;
        end else if (code == tap_pkg::OPC_EXTEST
                     || code == tap_pkg::OPC_INTEST
                     || code == tap_pkg::OPC_SAMPLE) begin
            dr_of = tap_pkg::SEL_BOUNDARY;
        end else if (code == tap_pkg::OPC_RUNT) begin
            dr_of = tap_pkg::SEL_CONTROL;
        end else begin
            dr_of = tap_pkg::SEL_BYPASS;
        end
    endfunction

    // Controller state graph
    function automatic tap_pkg::tap_state_t next_of(
        input tap_pkg::tap_state_t s, input logic tms);
        unique case (s)
            tap_pkg::TEST_LOGIC_RESET: next_of = tms ?
                tap_pkg::TEST_LOGIC_RESET : tap_pkg::RUN_TEST_IDLE;
            tap_pkg::RUN_TEST_IDLE: next_of = tms ?
                tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
            tap_pkg::SELECT_DR: next_of = tms ?
                tap_pkg::SELECT_IR : tap_pkg::CAPTURE_DR;
            tap_pkg::CAPTURE_DR: next_of = tms ?
                tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::SHIFT_DR: next_of = tms ?
                tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
            tap_pkg::EXIT1_DR: next_of = tms ?
                tap_pkg::UPDATE_DR : tap_pkg::PAUSE_DR;
            tap_pkg::PAUSE_DR: next_of = tms ?
                tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
            tap_pkg::EXIT2_DR: next_of = tms ?
                tap_pkg::UPDATE_DR : tap_pkg::SHIFT_DR;
            tap_pkg::UPDATE_DR: next_of = tms ?
                tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
            tap_pkg::SELECT_IR: next_of = tms ?
                tap_pkg::TEST_LOGIC_RESET : tap_pkg::CAPTURE_IR;
            tap_pkg::CAPTURE_IR: next_of = tms ?
                tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::SHIFT_IR: next_of = tms ?
                tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
            tap_pkg::EXIT1_IR: next_of = tms ?
                tap_pkg::UPDATE_IR : tap_pkg::PAUSE_IR;
            tap_pkg::PAUSE_IR: next_of = tms ?
                tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
            tap_pkg::EXIT2_IR: next_of = tms ?
                tap_pkg::UPDATE_IR : tap_pkg::SHIFT_IR;
            tap_pkg::UPDATE_IR: next_of = tms ?
                tap_pkg::SELECT_DR : tap_pkg::RUN_TEST_IDLE;
        endcase
    endfunction

    // Pins come from the master's domain
    pin_sync #(
        .W(3),
        .RST(3'h3)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i({tck_i, tms_i, tdi_i}),
        .sync_o({tck_s, tms_s, tdi_s})
    );

    // Test-clock edge detection on the synchronised level
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tck_prev_q <= 1'b0;
        end else if (ce_i) begin
            tck_prev_q <= tck_s;
        end
    end

    assign rise_ev = ce_i & tck_s & ~tck_prev_q;
    assign fall_ev = ce_i & ~tck_s & tck_prev_q;
    assign state_d = next_of(state_q, tms_s);
    assign in_tlr = (state_q == tap_pkg::TEST_LOGIC_RESET);
    assign dr_sel = tap_pkg::dr_sel_t'(dr_of(ir_q));

    // Controller state steps on each rise
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= tap_pkg::TEST_LOGIC_RESET;
        end else if (rise_ev) begin
            state_q <= state_d;
        end
    end

    // Instruction register: status capture, shift, update on fall
    scan_reg #(
        .W(tap_pkg::IR_W),
        .RST(tap_pkg::IR_RESET)
    ) u_ir (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .clear_i(in_tlr),
        .capture_i(rise_ev && state_q == tap_pkg::CAPTURE_IR),
        .cap_data_i(tap_pkg::IR_STATUS),
        .shift_i(rise_ev && state_q == tap_pkg::SHIFT_IR),
        .sdi_i(tdi_s),
        .update_i(fall_ev && state_q == tap_pkg::UPDATE_IR),
        .shift_q_o(ir_shift),
        .shadow_o(ir_q)
    );

    // Boundary chain captures pins and updates on the chosen opcodes
    assign bnd_cap = rise_ev && state_q == tap_pkg::CAPTURE_DR
        && dr_sel == tap_pkg::SEL_BOUNDARY;
    assign bnd_upd = fall_ev && state_q == tap_pkg::UPDATE_DR
        && dr_sel == tap_pkg::SEL_BOUNDARY;
    assign ctrl_upd = fall_ev && state_q == tap_pkg::UPDATE_DR
        && dr_sel == tap_pkg::SEL_CONTROL;

    scan_reg #(
        .W(tap_pkg::BND_W),
        .RST(tap_pkg::BND_RESET)
    ) u_bnd (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .clear_i(in_tlr),
        .capture_i(bnd_cap),
        .cap_data_i(bnd_capture_i),
        .shift_i(rise_ev && state_q == tap_pkg::SHIFT_DR
            && dr_sel == tap_pkg::SEL_BOUNDARY),
        .sdi_i(tdi_s),
        .update_i(bnd_upd),
        .shift_q_o(bnd_shift),
        .shadow_o(bnd_drive_o)
    );

    // Control register keeps its shift stage during capture
    scan_reg #(
        .W(tap_pkg::CTRL_W),
        .RST(tap_pkg::CTRL_RESET)
    ) u_ctrl (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .clear_i(in_tlr),
        .capture_i(1'b0),
        .cap_data_i(tap_pkg::CTRL_RESET),
        .shift_i(rise_ev && state_q == tap_pkg::SHIFT_DR
            && dr_sel == tap_pkg::SEL_CONTROL),
        .sdi_i(tdi_s),
        .update_i(ctrl_upd),
        .shift_q_o(ctrl_shift),
        .shadow_o(boundary_control_reg_o)
    );

    // Bypass: a single shift stage with no shadow
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bypass_q <= 1'b0;
        end else if (rise_ev && dr_sel == tap_pkg::SEL_BYPASS) begin
            if (state_q == tap_pkg::CAPTURE_DR) begin
                bypass_q <= 1'b0;
            end else if (state_q == tap_pkg::SHIFT_DR) begin
                bypass_q <= tdi_s;
            end
        end
    end

    // Least significant bit of the path now being shifted
    always_comb begin
        if (state_q == tap_pkg::SHIFT_IR) begin
            serial_bit = ir_shift[0];
        end else begin
            unique case (dr_sel)
                tap_pkg::SEL_BOUNDARY: serial_bit = bnd_shift[0];
                tap_pkg::SEL_CONTROL: serial_bit = ctrl_shift[0];
                default: serial_bit = bypass_q;
            endcase
        end
    end

    // Serial out and its enable change only on falls
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (fall_ev) begin
            tdo_oe_o <= state_q == tap_pkg::SHIFT_DR
                || state_q == tap_pkg::SHIFT_IR;
            tdo_o <= serial_bit;
        end
    end

    // Mode outputs follow the current instruction
    assign test_mode_o = ir_q == tap_pkg::OPC_EXTEST
        || ir_q == tap_pkg::OPC_INTEST
        || ir_q == tap_pkg::OPC_HIGHZ;
    assign outputs_highz_o = ir_q == tap_pkg::OPC_HIGHZ;
    assign run_test_o = state_q == tap_pkg::RUN_TEST_IDLE
        && dr_sel == tap_pkg::SEL_CONTROL;
    assign instruction_o = ir_q;

    // Helper: consecutive rises seen with mode select high
    logic [2:0] tms_rises_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tms_rises_q <= 3'h0;
        end else if (rise_ev) begin
            if (!tms_s) begin
                tms_rises_q <= 3'h0;
            end else if (tms_rises_q != tap_pkg::RISE_CNT_MAX) begin
                tms_rises_q <= tms_rises_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_enter_shift_ir;
        rise_ev && state_q == tap_pkg::CAPTURE_IR && !tms_s;
    endsequence
    sequence s_first_fall_in_shift;
        fall_ev && state_q == tap_pkg::SHIFT_IR;
    endsequence

    chk_tlr_five_rises: assert property (
        tms_rises_q >= 3'(tap_pkg::TLR_MAX_RISES) |-> in_tlr)
        else $error("reset state not reached after five high rises");
    chk_ir_reset_ones: assert property (
        in_tlr && $past(in_tlr) |-> ir_q == tap_pkg::IR_RESET)
        else $error("instruction not all ones in reset state");
    chk_bnd_reset_zero: assert property (
        in_tlr && $past(in_tlr) |-> bnd_drive_o == tap_pkg::BND_RESET)
        else $error("boundary chain not cleared in reset state");
    chk_ctrl_reset_val: assert property (
        in_tlr && $past(in_tlr)
        |-> boundary_control_reg_o == tap_pkg::CTRL_RESET)
        else $error("control register not reset in reset state");
    chk_select_one_clock: assert property (
        rise_ev && (state_q == tap_pkg::SELECT_DR
            || state_q == tap_pkg::SELECT_IR)
        |=> state_q != $past(state_q))
        else $error("select state held across a rise");
    chk_ir_status_load: assert property (
        s_enter_shift_ir |=> ir_shift == tap_pkg::IR_STATUS
            && state_q == tap_pkg::SHIFT_IR)
        else $error("status pattern not captured");
    chk_shift_out_on: assert property (
        s_enter_shift_ir ##[1:20] s_first_fall_in_shift
        |=> tdo_oe_o && tdo_o == $past(ir_shift[0]))
        else $error("serial out not driving instruction bit");
    chk_shift_out_off: assert property (
        fall_ev && (state_q == tap_pkg::EXIT1_DR
            || state_q == tap_pkg::EXIT1_IR) |=> !tdo_oe_o)
        else $error("serial out still driven in exit state");
    chk_pause_holds: assert property (
        state_q == tap_pkg::PAUSE_IR && $past(state_q) == tap_pkg::PAUSE_IR
        |-> $stable(ir_shift))
        else $error("instruction stage changed during pause");
    chk_bypass_zero: assert property (
        rise_ev && state_q == tap_pkg::CAPTURE_DR
            && dr_sel == tap_pkg::SEL_BYPASS |=> !bypass_q)
        else $error("bypass did not capture zero");
    chk_ir_update_fall: assert property (
        fall_ev && state_q == tap_pkg::UPDATE_IR |=> ir_q == ir_shift)
        else $error("instruction not updated on fall");
endmodule // boundary_scan_tap_controller
`default_nettype wire

// ### verif/tap_master_model.sv
// Test bus master model that steps the scan controller one test clock a call
`timescale 1ns/1ns
`default_nettype none
module tap_master_model (
    input wire logic clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    // Test clock stands low between calls; mode select starts high
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // One test-clock period; serial out is taken just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo,
                        output logic oe);
        @(negedge clk_i);
        tms_o = tms;
        tdi_o = tdi;
        repeat (6) @(negedge clk_i);
        tdo = tdo_i;
        oe = tdo_oe_i;
        tck_o = 1'b1;
        repeat (6) @(negedge clk_i);
        tck_o = 1'b0;
    endtask
endmodule // tap_master_model
`default_nettype wire

// ### verif/boundary_scan_tap_controller_test.sv
// Self-checking bench for the scan test controller
`timescale 1ns/1ns
`default_nettype none
module boundary_scan_tap_controller_test;
    logic clk, rst_n, tck, tms, tdi, tdo, tdo_oe, test_mode, highz, run_test;
    logic [39:0] bnd_cap, bnd_drive;
    logic [10:0] ctrl;
    logic ce;
    logic [7:0] instr;
    int n_errors = 0;
    int compares = 0;

    // Clock at 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    boundary_scan_tap_controller u_dut (
        .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .bnd_capture_i(bnd_cap), .tdo_o(tdo),
        .tdo_oe_o(tdo_oe), .test_mode_o(test_mode),
        .outputs_highz_o(highz), .run_test_o(run_test),
        .bnd_drive_o(bnd_drive), .boundary_control_reg_o(ctrl),
        .instruction_o(instr)
    );

    tap_master_model m (
        .clk_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi)
    );

    // Compare and report one value
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Full scan from idle back to idle, optional pause after pause_at bits
    task automatic scan(input logic ir, input int w, input logic [39:0] din,
                        input int pause_at, output logic [39:0] dout);
        logic t, o;
        dout = '0;
        m.step(1'b1, 1'b1, t, o);
        if (ir)
            m.step(1'b1, 1'b1, t, o);
        m.step(1'b0, 1'b1, t, o);
        m.step(1'b0, 1'b1, t, o);
        for (int i = 0; i < w; i++) begin
            m.step(i == w - 1 || i == pause_at - 1, din[i], t, o);
            dout[i] = t;
            check(o, 1'b1);
            if (i == pause_at - 1 && i != w - 1) begin
                m.step(1'b0, 1'b1, t, o);
                check(o, 1'b0);
                repeat (3) m.step(1'b0, 1'b0, t, o);
                m.step(1'b1, 1'b0, t, o);
                m.step(1'b0, 1'b0, t, o);
            end
        end
        m.step(1'b1, 1'b1, t, o);
        check(o, 1'b0);
        m.step(1'b0, 1'b1, t, o);
    endtask

    // Instruction load; every instruction scan returns the status pattern
    task automatic ir_load(input logic [7:0] op, input int pause_at);
        logic [39:0] q;
        scan(1'b1, 8, {32'h0, op}, pause_at, q);
        check(q[7:0], tap_pkg::IR_STATUS);
        check(instr, op);
    endtask

    task automatic reset_values();
        check(instr, tap_pkg::IR_RESET);
        check(bnd_drive, tap_pkg::BND_RESET);
        check(ctrl, tap_pkg::CTRL_RESET);
        check({tdo_oe, test_mode, run_test}, 3'h0);
    endtask

    // Control register scan, pause in the instruction scan, run in idle
    task automatic control_case();
        logic [39:0] q;
        logic t, o;
        m.step(1'b0, 1'b1, t, o);
        ir_load(tap_pkg::OPC_RUNT, 4);
        check(run_test, 1'b1);
        // Clock enable low: a whole test-clock pulse must leave idle alone
        ce = 1'b0;
        m.step(1'b1, 1'b1, t, o);
        check(run_test, 1'b1);
        ce = 1'b1;
        scan(1'b0, 11, 40'h5a3, 0, q);
        check(ctrl, 11'h5a3);
        scan(1'b0, 11, 40'h1c4, 0, q);
        check(q[10:0], 11'h5a3);
        check(ctrl, 11'h1c4);
    endtask

    // Five mode-select highs from data shift reach the reset state
    task automatic reset_case();
        logic t, o;
        m.step(1'b1, 1'b1, t, o);
        check(run_test, 1'b0);
        m.step(1'b0, 1'b1, t, o);
        m.step(1'b0, 1'b1, t, o);
        repeat (4) m.step(1'b1, 1'b1, t, o);
        check(instr, tap_pkg::OPC_RUNT);
        m.step(1'b1, 1'b1, t, o);
        reset_values();
        m.step(1'b0, 1'b1, t, o);
    endtask

    // Bypass path captures zero and delays data one bit
    task automatic bypass_case();
        logic [7:0] ops [3] = '{8'hff, 8'h84, 8'h05};
        logic [39:0] q;
        foreach (ops[k]) begin
            ir_load(ops[k], 0);
            scan(1'b0, 8, 40'hb2, 0, q);
            check(q[7:0], 8'h64);
        end
    endtask

    // Boundary chain capture, shift and shadow update, then mode changes
    task automatic boundary_case();
        logic [39:0] q;
        ir_load(tap_pkg::OPC_SAMPLE, 0);
        check(test_mode, 1'b0);
        scan(1'b0, 40, 40'h1e_2d3c_4b5a, 0, q);
        check(q, 40'hc3_5a96_0f1e);
        check(bnd_drive, 40'h1e_2d3c_4b5a);
        ir_load(tap_pkg::OPC_EXTEST, 0);
        check(test_mode, 1'b1);
        ir_load(tap_pkg::OPC_HIGHZ, 0);
        check(highz, 1'b1);
        ir_load(tap_pkg::OPC_INTEST, 0);
        check({test_mode, highz}, 2'h2);
    endtask

    // Watchdog cuts a hang short
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        bnd_cap = 40'hc3_5a96_0f1e;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        reset_values();
        control_case();
        reset_case();
        bypass_case();
        boundary_case();
        give_verdict();
    end
endmodule // boundary_scan_tap_controller_test
`default_nettype wire
